/* pkg/hs_pkg.sv */
/*
 * Shared constants of the homing sequencer: mode codes, leg encodings,
 * state type and reset values.
 * Assumes a single 50 MHz clock domain and no software-visible registers.
 */
package hs_pkg;
    // Mode field width and supported range
    localparam int MODE_W = 4;
    localparam logic [MODE_W-1:0] MODE_MIN = 4'h2;
    localparam logic [MODE_W-1:0] MODE_MAX = 4'h8;
    localparam logic [MODE_W-1:0] MODE_LIMIT = 4'h2;
    localparam logic [MODE_W-1:0] MODE_GUARD_LO = 4'h3;
    localparam logic [MODE_W-1:0] MODE_GUARD_HI = 4'h6;
    localparam logic [MODE_W-1:0] MODE_TRIP_LO = 4'h7;

    // Start variant codes
    localparam logic [1:0] VAR_CLEAR = 2'h0;
    localparam logic [1:0] VAR_ACTIVE = 2'h1;
    localparam logic [1:0] VAR_BEHIND = 2'h1;
    localparam logic [1:0] VAR_ON_HOME = 2'h2;

    // Leg descriptor fields: {direction, speed, event, action}
    localparam int LEG_W = 6;
    localparam int LEG_IDX_W = 3;
    localparam logic DIR_FWD = 1'b1;
    localparam logic DIR_REV = 1'b0;
    localparam logic SPD_HI = 1'b1;
    localparam logic SPD_LO = 1'b0;
    localparam logic [1:0] EV_FL_RISE = 2'h0;
    localparam logic [1:0] EV_FL_FALL = 2'h1;
    localparam logic [1:0] EV_HS_RISE = 2'h2;
    localparam logic [1:0] EV_HS_FALL = 2'h3;
    localparam logic [1:0] ACT_STOP = 2'h0;
    localparam logic [1:0] ACT_SLOW = 2'h1;
    localparam logic [1:0] ACT_INDEX = 2'h2;

    // Switch input bit positions in the synchroniser vector
    localparam int SW_FL = 0;
    localparam int SW_RL = 1;
    localparam int SW_HS = 2;
    localparam int SW_IDX = 3;
    localparam int SW_N = 4;

    // Reset values
    localparam logic [LEG_IDX_W-1:0] LEG_RESET = 3'h0;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;

    // Sequencer states
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_MOVE,
        HS_BRAKE,
        HS_SEARCH
    } hs_state_type;
endpackage

/* verilog/hs_sync_edge.sv */
/*
 * Two-flop synchroniser with a third stage for edge detection,
 * one lane per input bit.
 * Assumes inputs are asynchronous pins; outputs are on clk.
 */
`timescale 1ns/1ps
module hs_sync_edge #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Raw pins
    input wire logic [WIDTH-1:0] pinIn,
    // Synchronised level and edges
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    genvar i;
    // One synchroniser lane per pin
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gLane
            logic meta_reg; // First stage, read only by second stage
            logic sync_reg; // Second stage, clean level
            logic prev_reg; // Delayed level for edges
            // Shift the pin through three flops
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    prev_reg <= 1'b0;
                end else begin
                    meta_reg <= pinIn[i];
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                end
            end
            assign level[i] = sync_reg;
            assign rise[i] = sync_reg & ~prev_reg;
            assign fall[i] = ~sync_reg & prev_reg;
        end
    endgenerate
endmodule

/* verilog/hs_homing_seq.sv */
/*
 * Homing sequencer for modes 2 to 8: drives direction and speed commands
 * from limit and home switch states, captures home at the index pulse.
 * Assumes a motion stage that follows the run/speed/decel commands and
 * reports standstill on motorStopped, all on clk.
 */
`timescale 1ns/1ps
// Behaviour
// - Mode 2 clear: fast forward, slow reverse, index
// - Mode 2 limit active: slow reverse, index
// - Mode 3: index after switch falls reversing
// - Modes 3-6: any limit active aborts with alarm
// - Mode 4: index after switch rises slow forward
// - Mode 5: index after switch falls slow forward
// - Mode 6: index after switch rises slow reverse
// - Modes 7-8: first forward limit reverses, else alarm
// - Mode 7 ahead: limit, fast back, slow re-entry
// - Mode 7 behind: fast forward, slow reverse, index; on home: slow reverse, index
// - Mode 8 ahead: limit, back, slow forward index
module hs_homing_seq #(
    parameter int SPEED_W = 16,
    parameter int POS_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Homing command, same clock domain
    input wire logic start,
    input wire logic [hs_pkg::MODE_W-1:0] homeMode,
    input wire logic startAheadOfHome,
    // Configured speeds and deceleration
    input wire logic [SPEED_W-1:0] highSpeed,
    input wire logic [SPEED_W-1:0] lowSpeed,
    input wire logic [SPEED_W-1:0] decelSetting,
    // Motion stage feedback
    input wire logic motorStopped,
    input wire logic [POS_W-1:0] axisPosition,
    // Switch and encoder pins
    input wire logic forward_limit_switch,
    input wire logic reverse_limit_switch,
    input wire logic home_switch,
    input wire logic encoderIndex,
    // Motor commands
    output logic motorRun,
    output logic motorForward,
    output logic [SPEED_W-1:0] speedCmd,
    output logic [SPEED_W-1:0] decelCmd,
    // Homing status
    output logic busy,
    output logic homeDone,
    output logic homeAlarm,
    output logic [POS_W-1:0] homePosition
);
    import hs_pkg::*;

    hs_state_type state_reg, state_next; // Sequencer state
    logic [LEG_IDX_W-1:0] leg_reg, leg_next; // Current leg of the plan
    logic [1:0] variant_reg, variant_next; // Start-condition variant
    logic [MODE_W-1:0] mode_reg, mode_next; // Mode latched at start
    logic flSeen_reg; // Forward limit already met
    logic motorRun_reg, motorForward_reg, busy_reg; // Command flops
    logic homeDone_reg, homeAlarm_reg; // Status flops
    logic [SPEED_W-1:0] speedCmd_reg, decelCmd_reg;
    logic [POS_W-1:0] homePosition_reg;
    logic [SW_N-1:0] swLevel, swRise, swFall; // Synchronised switches

    // Leg plan: direction, speed, exit event and action per mode/variant/leg
    function automatic logic [LEG_W-1:0] hs_leg(input logic [MODE_W-1:0] m,
            input logic [1:0] v, input logic [LEG_IDX_W-1:0] l);
        logic [LEG_W-1:0] r;
        r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_INDEX};
        case ({m, v, l})
            {4'h2, 2'h0, 3'h0}: r = {DIR_FWD, SPD_HI, EV_FL_RISE, ACT_STOP};
            {4'h2, 2'h0, 3'h1}: r = {DIR_REV, SPD_LO, EV_FL_FALL, ACT_INDEX};
            {4'h2, 2'h1, 3'h0}: r = {DIR_REV, SPD_LO, EV_FL_FALL, ACT_INDEX};
            {4'h3, 2'h0, 3'h0}: r = {DIR_FWD, SPD_HI, EV_HS_RISE, ACT_STOP};
            {4'h3, 2'h0, 3'h1}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_INDEX};
            {4'h3, 2'h1, 3'h0}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_INDEX};
            {4'h4, 2'h0, 3'h0}: r = {DIR_FWD, SPD_HI, EV_HS_RISE, ACT_STOP};
            {4'h4, 2'h0, 3'h1}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h4, 2'h0, 3'h2}: r = {DIR_FWD, SPD_LO, EV_HS_RISE, ACT_INDEX};
            {4'h4, 2'h1, 3'h0}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h4, 2'h1, 3'h1}: r = {DIR_FWD, SPD_LO, EV_HS_RISE, ACT_INDEX};
            {4'h5, 2'h0, 3'h0}: r = {DIR_REV, SPD_HI, EV_HS_RISE, ACT_STOP};
            {4'h5, 2'h0, 3'h1}: r = {DIR_FWD, SPD_LO, EV_HS_FALL, ACT_INDEX};
            {4'h5, 2'h1, 3'h0}: r = {DIR_FWD, SPD_LO, EV_HS_FALL, ACT_INDEX};
            {4'h6, 2'h0, 3'h0}: r = {DIR_REV, SPD_HI, EV_HS_RISE, ACT_STOP};
            {4'h6, 2'h0, 3'h1}: r = {DIR_FWD, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h6, 2'h0, 3'h2}: r = {DIR_REV, SPD_LO, EV_HS_RISE, ACT_INDEX};
            {4'h6, 2'h1, 3'h0}: r = {DIR_FWD, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h6, 2'h1, 3'h1}: r = {DIR_REV, SPD_LO, EV_HS_RISE, ACT_INDEX};
            {4'h7, 2'h0, 3'h0}: r = {DIR_FWD, SPD_HI, EV_FL_RISE, ACT_STOP};
            {4'h7, 2'h0, 3'h1}: r = {DIR_REV, SPD_HI, EV_HS_RISE, ACT_SLOW};
            {4'h7, 2'h0, 3'h2}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h7, 2'h0, 3'h3}: r = {DIR_FWD, SPD_LO, EV_HS_RISE, ACT_STOP};
            {4'h7, 2'h0, 3'h4}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_INDEX};
            {4'h7, 2'h1, 3'h0}: r = {DIR_FWD, SPD_HI, EV_HS_RISE, ACT_STOP};
            {4'h7, 2'h1, 3'h1}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_INDEX};
            {4'h7, 2'h2, 3'h0}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_INDEX};
            {4'h8, 2'h0, 3'h0}: r = {DIR_FWD, SPD_HI, EV_FL_RISE, ACT_STOP};
            {4'h8, 2'h0, 3'h1}: r = {DIR_REV, SPD_HI, EV_HS_RISE, ACT_SLOW};
            {4'h8, 2'h0, 3'h2}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h8, 2'h0, 3'h3}: r = {DIR_FWD, SPD_LO, EV_HS_RISE, ACT_INDEX};
            {4'h8, 2'h1, 3'h0}: r = {DIR_FWD, SPD_HI, EV_HS_RISE, ACT_STOP};
            {4'h8, 2'h1, 3'h1}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h8, 2'h1, 3'h2}: r = {DIR_FWD, SPD_LO, EV_HS_RISE, ACT_INDEX};
            {4'h8, 2'h2, 3'h0}: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_STOP};
            {4'h8, 2'h2, 3'h1}: r = {DIR_FWD, SPD_LO, EV_HS_RISE, ACT_INDEX};
            default: r = {DIR_REV, SPD_LO, EV_HS_FALL, ACT_INDEX};
        endcase
        return r;
    endfunction

    // Synchronise switch and index pins
    hs_sync_edge #(.WIDTH(SW_N)) uSync (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn({encoderIndex, home_switch, reverse_limit_switch, forward_limit_switch}),
        .level(swLevel),
        .rise(swRise),
        .fall(swFall)
    );

    // Current leg decode
    wire [LEG_W-1:0] curLeg = hs_leg(mode_reg, variant_reg, leg_reg);
    wire curFwd = curLeg[5];
    wire [1:0] curEv = curLeg[3:2];
    wire [1:0] curAct = curLeg[1:0];
    // Exit event of the current leg
    wire evHit = (curEv == EV_FL_RISE) ? swRise[SW_FL] :
                 (curEv == EV_FL_FALL) ? swFall[SW_FL] :
                 (curEv == EV_HS_RISE) ? swRise[SW_HS] : swFall[SW_HS];
    // Mode classes
    wire modeOk = (homeMode >= MODE_MIN) && (homeMode <= MODE_MAX);
    wire guardMode = (mode_reg >= MODE_GUARD_LO) && (mode_reg <= MODE_GUARD_HI);
    wire tripMode = (mode_reg >= MODE_TRIP_LO);
    wire startTrip = (homeMode >= MODE_TRIP_LO);
    wire running = (state_reg != HS_IDLE);
    // Variant picked from switch states at start
    wire [1:0] startVariant = (homeMode == MODE_LIMIT) ?
                                  (swLevel[SW_FL] ? VAR_ACTIVE : VAR_CLEAR) :
                              !startTrip ? (swLevel[SW_HS] ? VAR_ACTIVE : VAR_CLEAR) :
                              swLevel[SW_HS] ? VAR_ON_HOME :
                              (startAheadOfHome ? VAR_CLEAR : VAR_BEHIND);
    // Forward limit met while moving forward
    wire flFwdHit = swRise[SW_FL] & motorForward_reg;
    // Abort conditions
    wire guardTrip = guardMode & (swLevel[SW_FL] | swLevel[SW_RL]);
    wire tripAbort = tripMode & (swLevel[SW_RL] | (flFwdHit & flSeen_reg));
    wire alarmHit = running & (guardTrip | tripAbort);
    // First forward limit outside a planned limit leg turns the axis round
    wire firstTrip = (state_reg == HS_MOVE) & tripMode & swRise[SW_FL] & curFwd
                     & ~flSeen_reg & (curEv != EV_FL_RISE);
    wire indexHit = (state_reg == HS_SEARCH) & swRise[SW_IDX] & ~alarmHit;
    wire startOk = (state_reg == HS_IDLE) & start & modeOk;
    wire startBad = (state_reg == HS_IDLE) & start & ~modeOk;
    // Next leg decode for the command flops
    wire [LEG_W-1:0] nextLeg = hs_leg(mode_next, variant_next, leg_next);
    wire nextRun = (state_next == HS_MOVE) || (state_next == HS_SEARCH);

    // Next-state logic of the sequencer
    always_comb begin
        state_next = state_reg;
        leg_next = leg_reg;
        variant_next = variant_reg;
        mode_next = mode_reg;
        case (state_reg)
            HS_IDLE: begin
                if (startOk) begin
                    state_next = HS_MOVE;
                    leg_next = LEG_RESET;
                    variant_next = startVariant;
                    mode_next = homeMode;
                end
            end
            HS_MOVE: begin
                if (alarmHit) begin
                    state_next = HS_IDLE;
                end else if (firstTrip) begin
                    // Restart as if starting ahead of home: brake, then fast reverse
                    state_next = HS_BRAKE;
                    variant_next = VAR_CLEAR;
                    leg_next = 3'h1;
                end else if (evHit) begin
                    if (curAct == ACT_STOP) begin
                        state_next = HS_BRAKE;
                        leg_next = leg_reg + 3'h1;
                    end else if (curAct == ACT_SLOW) begin
                        leg_next = leg_reg + 3'h1;
                    end else begin
                        state_next = HS_SEARCH;
                    end
                end
            end
            HS_BRAKE: begin
                // Wait for standstill before the next leg
                if (alarmHit) begin
                    state_next = HS_IDLE;
                end else if (motorStopped) begin
                    state_next = HS_MOVE;
                end
            end
            HS_SEARCH: begin
                // Keep moving until the first index edge
                if (alarmHit || indexHit) begin
                    state_next = HS_IDLE;
                end
            end
            default: begin
                state_next = HS_IDLE;
            end
        endcase
    end

    // Sequencer state flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= HS_IDLE;
            leg_reg <= LEG_RESET;
            variant_reg <= VAR_CLEAR;
            mode_reg <= MODE_RESET;
            flSeen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            leg_reg <= leg_next;
            variant_reg <= variant_next;
            mode_reg <= mode_next;
            flSeen_reg <= startOk ? 1'b0 : (flSeen_reg | (running & flFwdHit));
        end
    end

    // Motor command flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            motorRun_reg <= 1'b0;
            motorForward_reg <= 1'b0;
            speedCmd_reg <= '0;
            decelCmd_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            motorRun_reg <= nextRun;
            motorForward_reg <= nextLeg[5];
            speedCmd_reg <= nextRun ? (nextLeg[4] ? highSpeed : lowSpeed) : '0;
            decelCmd_reg <= decelSetting;
            busy_reg <= (state_next != HS_IDLE);
        end
    end

    // Completion, alarm and home capture
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            homeDone_reg <= 1'b0;
            homeAlarm_reg <= 1'b0;
            homePosition_reg <= '0;
        end else begin
            homeDone_reg <= indexHit | (homeDone_reg & ~(start & ~running));
            homeAlarm_reg <= alarmHit | startBad | (homeAlarm_reg & ~startOk);
            if (indexHit) begin
                homePosition_reg <= axisPosition;
            end
        end
    end

    assign motorRun = motorRun_reg;
    assign motorForward = motorForward_reg;
    assign speedCmd = speedCmd_reg;
    assign decelCmd = decelCmd_reg;
    assign busy = busy_reg;
    assign homeDone = homeDone_reg;
    assign homeAlarm = homeAlarm_reg;
    assign homePosition = homePosition_reg;
endmodule

/* sim/hs_homing_seq_properties.sv */
/* Port assertions for the homing sequencer.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module hs_homing_seq_properties #(
    parameter int SPEED_W = 16,
    parameter int POS_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command and configuration
    input wire logic start,
    input wire logic [hs_pkg::MODE_W-1:0] homeMode,
    input wire logic [SPEED_W-1:0] highSpeed,
    input wire logic [SPEED_W-1:0] lowSpeed,
    input wire logic [SPEED_W-1:0] decelSetting,
    // Pins
    input wire logic forward_limit_switch,
    input wire logic reverse_limit_switch,
    input wire logic encoderIndex,
    // Outputs under watch
    input wire logic motorRun,
    input wire logic motorForward,
    input wire logic [SPEED_W-1:0] speedCmd,
    input wire logic [SPEED_W-1:0] decelCmd,
    input wire logic busy,
    input wire logic homeDone,
    input wire logic homeAlarm,
    input wire logic [POS_W-1:0] homePosition
);
    import hs_pkg::*;
    // Modes that forbid any limit, and the limit-turning modes
    wire logic guardMode = (homeMode >= 4'h3) && (homeMode <= 4'h6);
    wire logic tripMode = (homeMode == 4'h7) || (homeMode == 4'h8);
    wire logic anyLimit = forward_limit_switch || reverse_limit_switch;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_decel_delay: assert property ($past(rst_b) |-> decelCmd == $past(decelSetting))
        else $error("decel command is not the setting of the cycle before");
    chk_speed_level: assert property (motorRun ?
        (speedCmd == highSpeed || speedCmd == lowSpeed) : speedCmd == '0)
        else $error("speed command off its configured levels");
    chk_start_move: assert property (!busy && start && homeMode == 4'h2 |=> busy && motorRun)
        else $error("mode 2 start did not set the axis moving");
    chk_start_dir: assert property (!busy && start && homeMode == 4'h2
        |=> motorForward == !$past(forward_limit_switch, 3))
        else $error("mode 2 start direction ignores the forward limit");
    chk_fwd_brake: assert property (busy && homeMode == 4'h2 && motorRun && motorForward
        && $rose(forward_limit_switch) |-> ##[2:4] !motorRun) else $error("no brake at limit");
    chk_guard_abort: assert property ((busy || start) && guardMode && anyLimit
        |-> ##[1:5] homeAlarm) else $error("limit in guarded mode raised no alarm");
    chk_rev_trip: assert property ((busy || start) && tripMode && reverse_limit_switch
        |-> ##[1:5] homeAlarm) else $error("reverse limit raised no alarm");
    chk_done_quiet: assert property ($rose(homeDone) |-> !busy && !motorRun && !homeAlarm)
        else $error("completion left the axis busy or running");
    chk_alarm_quiet: assert property ($rose(homeAlarm) |-> !busy && !motorRun)
        else $error("alarm left the axis busy or running");
    chk_index_cause: assert property ($rose(homeDone) |->
        $past(encoderIndex, 3) || $past(encoderIndex, 4)) else $error("home without index");
    chk_hold_home: assert property (!$rose(homeDone) |-> $stable(homePosition))
        else $error("home position changed without completion");
    chk_idle_still: assert property (!busy |-> !motorRun)
        else $error("motor driven while idle");
endmodule

bind hs_homing_seq hs_homing_seq_properties #(.SPEED_W(SPEED_W), .POS_W(POS_W)) i_props (
    .clk(clk), .rst_b(rst_b), .start(start), .homeMode(homeMode), .highSpeed(highSpeed),
    .lowSpeed(lowSpeed), .decelSetting(decelSetting), .forward_limit_switch(forward_limit_switch),
    .reverse_limit_switch(reverse_limit_switch), .encoderIndex(encoderIndex),
    .motorRun(motorRun), .motorForward(motorForward), .speedCmd(speedCmd), .decelCmd(decelCmd),
    .busy(busy), .homeDone(homeDone), .homeAlarm(homeAlarm), .homePosition(homePosition));

/* sim/hs_axis_model.sv */
/* Behavioural axis: motor, encoder index marks and the three switches.
   Assumes speed commands are positions per clock; coasts two cycles on stop. */
`timescale 1ns/1ps
module hs_axis_model (
    // Clock
    input wire logic clk,
    // Motor commands
    input wire logic motorRun,
    input wire logic motorForward,
    input wire logic [15:0] speedCmd,
    // Test placement of the axis
    input wire logic loadEn,
    input wire logic [31:0] loadPos,
    // Feedback and pins
    output logic motorStopped,
    output logic [31:0] axisPosition,
    output logic forward_limit_switch,
    output logic reverse_limit_switch,
    output logic home_switch,
    output logic encoderIndex
);
    int pos = 300; // Axis position
    int coast = 0; // Cycles of run-out left after the drive drops
    int spdHold = 0; // Speed kept for the run-out
    logic dirHold = 1'b1; // Direction kept for the run-out
    // Move the axis; braking is not instant, so it overshoots a little
    always @(posedge clk) begin
        if (loadEn) begin
            pos <= int'(loadPos);
            coast <= 0;
        end else if (motorRun) begin
            pos <= motorForward ? pos + int'(speedCmd) : pos - int'(speedCmd);
            dirHold <= motorForward;
            spdHold <= int'(speedCmd);
            coast <= 2;
        end else if (coast > 0) begin
            pos <= dirHold ? pos + spdHold : pos - spdHold;
            coast <= coast - 1;
        end
    end
    // Pins from geometry: limits at 1000 and above and at 100 and below, home zone 500 to 600
    assign axisPosition = 32'(pos);
    assign motorStopped = !motorRun && coast == 0;
    assign forward_limit_switch = pos >= 1000;
    assign reverse_limit_switch = pos <= 100;
    assign home_switch = pos >= 500 && pos <= 600;
    // Index mark four positions wide every 64, so fast travel cannot skip it
    assign encoderIndex = pos[5:0] < 6'h04;
endmodule

/* sim/tb.sv */
/* Self-checking bench: homing runs in every mode against the axis model.
   Assumes the checker is bound to the design by its own file. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    import hs_pkg::*;
    logic clk, rst_b, start, startAheadOfHome, loadEn, motorStopped;
    logic [MODE_W-1:0] homeMode;
    logic [15:0] highSpeed, lowSpeed, decelSetting, speedCmd, decelCmd, lfsr;
    logic [31:0] loadPos, axisPosition, homePosition;
    logic fwdLim, revLim, homeSw, index, motorRun, motorForward, busy, homeDone, homeAlarm;
    logic prevDone, prevAlarm, ea;
    logic [25:0] em;
    logic alarmQ[$]; // Expected alarm per run
    logic [25:0] markQ[$]; // Expected index mark per run
    int checks = 0;
    int miscompares = 0;
    int n;
    // Scenario table: mode, start position, ahead flag, alarm, index mark
    // Last three: first forward limit turns mode 7 round, mode 8 behind and on home
    int tMode[21] = '{2, 2, 3, 3, 3, 4, 4, 5, 5, 5, 6, 6, 7, 7, 7, 8, 9, 8, 7, 8, 8};
    int tPos[21] = '{300, 1010, 300, 550, 1010, 300, 550, 800, 550, 300, 800, 550, 800, 300,
        550, 800, 300, 50, 800, 300, 550};
    int tAhead[21] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0, 0};
    int tAlarm[21] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0};
    int tMark[21] = '{15, 15, 7, 7, 0, 8, 8, 10, 10, 0, 9, 9, 7, 7, 7, 8, 0, 0, 7, 8, 8};

    hs_homing_seq i_dut (.clk(clk), .rst_b(rst_b), .start(start), .homeMode(homeMode),
        .startAheadOfHome(startAheadOfHome), .highSpeed(highSpeed), .lowSpeed(lowSpeed),
        .decelSetting(decelSetting), .motorStopped(motorStopped), .axisPosition(axisPosition),
        .forward_limit_switch(fwdLim), .reverse_limit_switch(revLim), .home_switch(homeSw),
        .encoderIndex(index), .motorRun(motorRun), .motorForward(motorForward),
        .speedCmd(speedCmd), .decelCmd(decelCmd), .busy(busy), .homeDone(homeDone),
        .homeAlarm(homeAlarm), .homePosition(homePosition));
    hs_axis_model i_axis (.clk(clk), .motorRun(motorRun), .motorForward(motorForward),
        .speedCmd(speedCmd), .loadEn(loadEn), .loadPos(loadPos), .motorStopped(motorStopped),
        .axisPosition(axisPosition), .forward_limit_switch(fwdLim),
        .reverse_limit_switch(revLim), .home_switch(homeSw), .encoderIndex(index));

    // Pseudo-random sequence for the deceleration setting and ahead flag
    function automatic logic [15:0] lfsrNext(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Verdict and end of run
    task automatic close_out();
        `CHK("results outstanding", 0, alarmQ.size())
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Random deceleration setting every cycle; the sequence is seeded during reset
    always @(posedge clk) begin
        lfsr <= rst_b ? lfsrNext(lfsr) : 16'h5bf5;
        decelSetting <= lfsr;
    end

    // Result watcher: each completion or alarm takes the oldest expectation
    always @(negedge clk) begin
        if (rst_b && ((homeDone && !prevDone) || (homeAlarm && !prevAlarm))) begin
            if (alarmQ.size() == 0) begin
                `CHK("unexpected result", 1'b0, 1'b1)
            end else begin
                ea = alarmQ.pop_front();
                em = markQ.pop_front();
                `CHK("alarm", ea, homeAlarm)
                `CHK("done", !ea, homeDone)
                if (!ea) `CHK("home mark", em, homePosition[31:6])
            end
        end
        prevDone = homeDone;
        prevAlarm = homeAlarm;
    end

    // Watchdog for a hung run
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        close_out();
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        start = 1'b0;
        loadEn = 1'b0;
        loadPos = 32'h0;
        homeMode = 4'h2;
        startAheadOfHome = 1'b0;
        highSpeed = 16'h0004;
        lowSpeed = 16'h0001;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 21; i++) begin
            loadEn <= 1'b1;
            loadPos <= 32'(tPos[i]);
            homeMode <= 4'(tMode[i]);
            startAheadOfHome <= (tMode[i] >= 7) ? tAhead[i][0] : lfsr[0];
            @(posedge clk);
            loadEn <= 1'b0;
            repeat (4) @(posedge clk);
            start <= 1'b1;
            alarmQ.push_back(tAlarm[i][0]);
            markQ.push_back(26'(tMark[i]));
            @(posedge clk);
            start <= 1'b0;
            repeat (3) @(posedge clk);
            n = 0;
            while (!(homeDone === 1'b1 || homeAlarm === 1'b1) && n < 2000) begin
                @(posedge clk);
                n++;
            end
            if (n >= 2000) miscompares++;
            repeat (6) @(posedge clk);
            $display("test %0d mode %0d finished", i, tMode[i]);
        end
        close_out();
    end
endmodule
